// *** hw/brv_pkg.sv ***
package brv_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int AW = 16;
  localparam logic [AW-1:0] OFF_PAT_COL_LO = 16'h8110;
  localparam logic [AW-1:0] OFF_PAT_COL_HI = 16'h8114;
  localparam logic [AW-1:0] OFF_PAT_W0 = 16'h8120;
  localparam logic [AW-1:0] OFF_PAT_W1 = 16'h8124;
  localparam logic [AW-1:0] OFF_PAT_W2 = 16'h8128;
  localparam logic [AW-1:0] OFF_PAT_W3 = 16'h812c;
  localparam logic [AW-1:0] OFF_LV_WR = 16'h8140;
  localparam logic [AW-1:0] OFF_LV_RD = 16'h8144;
  localparam logic [AW-1:0] OFF_RASTER = 16'h8200;
  localparam logic [AW-1:0] OFF_LINE = 16'h8204;
  localparam logic [AW-1:0] OFF_BLOCK = 16'h8208;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int RC_KEYED = 12;
  localparam int RC_SRC_SKIP = 11;
  localparam int RC_PAT_SKIP = 10;
  localparam int RC_PFMT_LSB = 8;
  localparam int RC_COMBINE_LSB = 0;
  localparam int LC_FETCH = 3;
  localparam int LC_MINOR_POS = 2;
  localparam int LC_MAJOR_POS = 1;
  localparam int LC_VMAJOR = 0;
  localparam int BC_REV_Y = 8;
  localparam int BC_SFMT_LSB = 6;
  localparam int PIX_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PF_SOLID = 2'b00, PF_MONO = 2'b01, PF_DITHER = 2'b10, PF_COLOUR = 2'b11
  } brv_pfmt_t;
  typedef enum logic [1:0] {
    SF_COLOUR = 2'b00, SF_MONO = 2'b01, SF_UNUSED = 2'b10, SF_GLYPH = 2'b11
  } brv_sfmt_t;
  typedef struct packed {
    logic valid;
    logic [PIX_W-1:0] src;
    logic [PIX_W-1:0] dst;
    logic src_bit;
    logic [6:0] pat_idx;
  } brv_pix_in_t;
  typedef struct packed {
    logic valid;
    logic [PIX_W-1:0] pat;
    logic [PIX_W-1:0] value;
    logic draw;
  } brv_pix_out_t;
  typedef struct packed {
    logic x_move;
    logic x_neg;
    logic y_move;
    logic y_neg;
  } brv_step_t;
endpackage

// *** hw/brv_regs.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module brv_regs
  import brv_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [brv_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [brv_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pixel path
  input wire brv_pkg::brv_pix_in_t pix_in,
  output brv_pkg::brv_pix_out_t pix_out,
  // stepping requests
  input wire logic line_step,
  input wire logic line_minor,
  input wire logic row_end,
  // launches and stepping
  output logic raster_launch,
  output logic line_launch,
  output logic block_launch,
  output logic line_fetch_a,
  output logic source_expand,
  output brv_pkg::brv_step_t line_move,
  output brv_pkg::brv_step_t row_move
);
  import brv_pkg::*;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_take, w_take, ar_take, do_write, wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  assign aw_take = awvalid & awready_q;
  assign w_take = wvalid & wready_q;
  assign ar_take = arvalid & arready_q;
  // the write lands only once both halves are held and the answer is free
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      awready_q <= do_write | ~(aw_full_q | aw_take);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      wready_q <= 1'b0;
      w_data_q <= RST_WORD;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (w_take)
      begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (do_write)
        w_full_q <= 1'b0;
      wready_q <= do_write | ~(w_full_q | w_take);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= RST_WORD;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_hit ? rd_word : RST_WORD;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
        rvalid_q <= 1'b0;
      arready_q <= (rvalid_q & rready) | (~rvalid_q & ~ar_take);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************
  // register storage
  // ****************************************
  logic [31:0] col_lo_q, col_hi_q, lv_wr_q, lv_rd_q;
  logic [31:0] raster_q, line_q, block_q;
  logic [127:0] pat_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction

  always_comb
  begin
    wr_hit = 1'b1;
    case (aw_addr_q)
      OFF_PAT_COL_LO, OFF_PAT_COL_HI, OFF_PAT_W0, OFF_PAT_W1, OFF_PAT_W2,
      OFF_PAT_W3, OFF_LV_WR, OFF_LV_RD, OFF_RASTER, OFF_LINE, OFF_BLOCK:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_pat
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pat_q[32*g +: 32] <= RST_WORD;
        else if (do_write && aw_addr_q == OFF_PAT_W0 + AW'(4 * g))
          pat_q[32*g +: 32] <= merge(pat_q[32*g +: 32], w_data_q, w_strb_q);
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      col_lo_q <= RST_WORD;
      col_hi_q <= RST_WORD;
      lv_wr_q <= RST_WORD;
      lv_rd_q <= RST_WORD;
      raster_q <= RST_WORD;
      line_q <= RST_WORD;
      block_q <= RST_WORD;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        OFF_PAT_COL_LO: col_lo_q <= merge(col_lo_q, w_data_q, w_strb_q);
        OFF_PAT_COL_HI: col_hi_q <= merge(col_hi_q, w_data_q, w_strb_q);
        OFF_LV_WR: lv_wr_q <= merge(lv_wr_q, w_data_q, w_strb_q);
        OFF_LV_RD: lv_rd_q <= merge(lv_rd_q, w_data_q, w_strb_q);
        OFF_RASTER: raster_q <= merge(raster_q, w_data_q, w_strb_q) & 32'h0000_1fff;
        OFF_LINE: line_q <= merge(line_q, w_data_q, w_strb_q) & 32'h0000_000f;
        OFF_BLOCK: block_q <= merge(block_q, w_data_q, w_strb_q) & 32'h0000_01c0;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    case (araddr)
      OFF_PAT_COL_LO: rd_word = col_lo_q;
      OFF_PAT_COL_HI: rd_word = col_hi_q;
      OFF_PAT_W0: rd_word = pat_q[31:0];
      OFF_PAT_W1: rd_word = pat_q[63:32];
      OFF_PAT_W2: rd_word = pat_q[95:64];
      OFF_PAT_W3: rd_word = pat_q[127:96];
      OFF_LV_WR: rd_word = lv_wr_q;
      OFF_LV_RD: rd_word = lv_rd_q;
      OFF_RASTER: rd_word = raster_q;
      OFF_LINE: rd_word = line_q;
      OFF_BLOCK: rd_word = block_q;
      default:
      begin
        rd_word = RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // launches
  // ****************************************
  logic raster_launch_q, line_launch_q, block_launch_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      raster_launch_q <= 1'b0;
    else
      raster_launch_q <= do_write && aw_addr_q == OFF_RASTER;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_launch_q <= 1'b0;
    else
      line_launch_q <= do_write && aw_addr_q == OFF_LINE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      block_launch_q <= 1'b0;
    else
      block_launch_q <= do_write && aw_addr_q == OFF_BLOCK;
  end

  assign raster_launch = raster_launch_q;
  assign line_launch = line_launch_q;
  assign block_launch = block_launch_q;

  // ****************************************
  // pixel path
  // ****************************************
  brv_pfmt_t pfmt;
  logic [7:0] combine;
  logic [PIX_W-1:0] colour [4];
  logic [PIX_W-1:0] pat_val, rop_val;
  logic pat_bit, draw;
  logic [1:0] dith_sel;
  brv_pix_out_t pix_out_q;

  assign pfmt = brv_pfmt_t'(raster_q[RC_PFMT_LSB +: 2]);
  assign combine = raster_q[RC_COMBINE_LSB +: 8];
  assign colour[0] = col_lo_q[15:0];
  assign colour[1] = col_lo_q[31:16];
  assign colour[2] = col_hi_q[15:0];
  assign colour[3] = col_hi_q[31:16];
  assign pat_bit = pat_q[pix_in.pat_idx];
  assign dith_sel = {pat_q[{pix_in.pat_idx[5:0], 1'b1}], pat_q[{pix_in.pat_idx[5:0], 1'b0}]};

  always_comb
  begin
    case (pfmt)
      PF_SOLID: pat_val = colour[0];
      PF_MONO: pat_val = pat_bit ? colour[1] : colour[0];
      PF_DITHER: pat_val = colour[dith_sel];
      PF_COLOUR: pat_val = pat_q[PIX_W*pix_in.pat_idx[2:0] +: PIX_W];
      default: pat_val = colour[0];
    endcase
  end

  generate
    for (genvar i = 0; i < PIX_W; i++)
    begin : g_rop
      assign rop_val[i] = combine[{pat_val[i], pix_in.src[i], pix_in.dst[i]}];
    end
  endgenerate

  // the key rides in the destination lane, so keyed use costs no extra port
  always_comb
  begin
    draw = 1'b1;
    if (raster_q[RC_KEYED] && pix_in.src == pix_in.dst)
      draw = 1'b0;
    if (raster_q[RC_SRC_SKIP] && !pix_in.src_bit)
      draw = 1'b0;
    if (raster_q[RC_PAT_SKIP] && !pat_bit)
      draw = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pix_out_q <= '0;
    else
      pix_out_q <= '{valid: pix_in.valid, pat: pat_val, value: rop_val, draw: draw};
  end
  assign pix_out = pix_out_q;

  // ****************************************
  // line and row stepping
  // ****************************************
  logic line_fetch_q, source_expand_q;
  brv_step_t line_move_q, row_move_q;
  logic maj_neg, min_neg;

  assign maj_neg = ~line_q[LC_MAJOR_POS];
  assign min_neg = ~line_q[LC_MINOR_POS];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_move_q <= '0;
    else if (!line_step)
      line_move_q <= '0;
    else if (line_q[LC_VMAJOR])
      line_move_q <= '{x_move: line_minor, x_neg: min_neg, y_move: 1'b1, y_neg: maj_neg};
    else
      line_move_q <= '{x_move: 1'b1, x_neg: maj_neg, y_move: line_minor, y_neg: min_neg};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      row_move_q <= '0;
    else if (!row_end)
      row_move_q <= '0;
    else if (brv_sfmt_t'(block_q[BC_SFMT_LSB +: 2]) == SF_GLYPH)
      row_move_q <= '{x_move: 1'b1, x_neg: 1'b0, y_move: 1'b0, y_neg: 1'b0};
    else
      row_move_q <= '{x_move: 1'b0, x_neg: 1'b0, y_move: 1'b1, y_neg: block_q[BC_REV_Y]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_fetch_q <= 1'b0;
      source_expand_q <= 1'b0;
    end
    else
    begin
      line_fetch_q <= line_q[LC_FETCH];
      source_expand_q <= block_q[BC_SFMT_LSB];
    end
  end

  assign line_fetch_a = line_fetch_q;
  assign source_expand = source_expand_q;
  assign line_move = line_move_q;
  assign row_move = row_move_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_wr(logic [AW-1:0] a);
    do_write && aw_addr_q == a;
  endsequence

  chk_pat_word_two: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr(OFF_PAT_W2) ##0 w_strb_q == 4'hf |=> pat_q[95:64] == $past(w_data_q))
    else $error("pattern word two misplaced");
  chk_pat_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    raster_q[RC_PAT_SKIP] && !pat_bit |=> !pix_out.draw)
    else $error("clear pattern pixel drawn");
  chk_vmajor_step: assert property (@(posedge aclk) disable iff (!aresetn)
    line_step && line_q[LC_VMAJOR] |=> line_move.y_move)
    else $error("y major line not stepping y");
  chk_keyed_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    raster_q[RC_KEYED] && pix_in.src == pix_in.dst |=> !pix_out.draw)
    else $error("keyed pixel drawn");
  chk_src_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    raster_q[RC_SRC_SKIP] && !pix_in.src_bit |=> !pix_out.draw)
    else $error("clear source pixel drawn");
  chk_solid_pat: assert property (@(posedge aclk) disable iff (!aresetn)
    pfmt == PF_SOLID |=> pix_out.pat == $past(col_lo_q[15:0]))
    else $error("solid pattern not colour zero");
  chk_mono_pat: assert property (@(posedge aclk) disable iff (!aresetn)
    pfmt == PF_MONO && pat_bit |=> pix_out.pat == $past(col_lo_q[31:16]))
    else $error("mono set bit not colour one");
  chk_copy_rop: assert property (@(posedge aclk) disable iff (!aresetn)
    combine == 8'hf0 |=> pix_out.value == pix_out.pat)
    else $error("pattern copy code wrong");
  chk_raster_go: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr(OFF_RASTER) |=> raster_launch ##1 !raster_launch)
    else $error("raster launch not one pulse");
  chk_block_go: assert property (@(posedge aclk) disable iff (!aresetn)
    block_launch |-> $past(do_write) && $past(aw_addr_q) == OFF_BLOCK)
    else $error("block launch without write");
  chk_rev_row: assert property (@(posedge aclk) disable iff (!aresetn)
    row_end && block_q[BC_REV_Y] && block_q[7:6] != 2'b11 |=> row_move.y_neg)
    else $error("reverse row not negative");
endmodule

// *** verif/brv_regs_test.sv ***
`timescale 1ns/1ps
module brv_regs_test;
  import brv_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  localparam int LIMIT = 40000;
  logic aclk;
  logic aresetn;
  logic [AW-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [AW-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  brv_pix_in_t pix_in;
  brv_pix_out_t pix_out;
  logic line_step;
  logic line_minor;
  logic row_end;
  logic raster_launch;
  logic line_launch;
  logic block_launch;
  logic line_fetch_a;
  logic source_expand;
  brv_step_t line_move;
  brv_step_t row_move;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_rl = 0;
  int n_ll = 0;
  int n_bl = 0;
  int e_rl = 0;
  int e_ll = 0;
  int e_bl = 0;
  integer seed;
  logic [31:0] pw [4];
  logic [15:0] col [4];
  logic [31:0] rc;

  brv_regs i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pix_in, .pix_out, .line_step, .line_minor, .row_end, .raster_launch,
    .line_launch, .block_launch, .line_fetch_a, .source_expand, .line_move, .row_move
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // pulses are counted, so a launch stuck high shows up as extra counts
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    n_rl <= n_rl + int'(raster_launch === 1'b1);
    n_ll <= n_ll + int'(line_launch === 1'b1);
    n_bl <= n_bl + int'(block_launch === 1'b1);
    if (cycles == LIMIT)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic end_sim();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pix(input brv_pix_out_t got, input brv_pix_out_t exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_step(input brv_step_t got, input brv_step_t exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count is assumed here: only the bench timeout ends a stuck wait
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // write, then wait past the launch slot and compare every launch count
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, s, r);
    chk32(32'(r), 32'(er));
    if (er == RESP_OKAY)
    begin
      e_rl += int'(a == OFF_RASTER);
      e_ll += int'(a == OFF_LINE);
      e_bl += int'(a == OFF_BLOCK);
    end
    repeat (3) @(posedge aclk);
    #1;
    chk32(32'(n_rl), 32'(e_rl));
    chk32(32'(n_ll), 32'(e_ll));
    chk32(32'(n_bl), 32'(e_bl));
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk32(d, ed);
    chk32(32'(r), 32'(er));
  endtask

  function automatic brv_pix_out_t exp_pix(input brv_pix_in_t p);
    brv_pix_out_t o;
    logic [127:0] st;
    logic pb;
    o = '0;
    st = {pw[3], pw[2], pw[1], pw[0]};
    pb = st[p.pat_idx];
    case (rc[9:8])
      2'b00: o.pat = col[0];
      2'b01: o.pat = pb ? col[1] : col[0];
      2'b10: o.pat = col[{st[{p.pat_idx[5:0], 1'b1}], st[{p.pat_idx[5:0], 1'b0}]}];
      default: o.pat = st[16 * p.pat_idx[2:0] +: 16];
    endcase
    for (int k = 0; k < PIX_W; k++)
      o.value[k] = rc[{o.pat[k], p.src[k], p.dst[k]}];
    o.draw = !((rc[12] && p.src == p.dst) || (rc[11] && !p.src_bit) || (rc[10] && !pb));
    o.valid = p.valid;
    return o;
  endfunction

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    logic [AW-1:0] map [11];
    logic [31:0] d;
    logic [31:0] m;
    brv_pix_in_t p;
    brv_step_t s;
    seed = 32'hd8cc3b2f;
    map = '{OFF_PAT_COL_LO, OFF_PAT_COL_HI, OFF_PAT_W0, OFF_PAT_W1, OFF_PAT_W2,
            OFF_PAT_W3, OFF_LV_WR, OFF_LV_RD, OFF_RASTER, OFF_LINE, OFF_BLOCK};
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    pix_in = '0;
    line_step = 1'b0;
    line_minor = 1'b0;
    row_end = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 11; i++)
      rd(map[i], RST_WORD, RESP_OKAY);
    wr(16'h8118, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd(16'h8118, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 11; i++)
    begin
      d = $random(seed);
      m = (map[i] == OFF_RASTER) ? 32'h1fff : (map[i] == OFF_LINE) ? 32'hf :
          (map[i] == OFF_BLOCK) ? 32'h1c0 : 32'hffffffff;
      wr(map[i], d, 4'hf, RESP_OKAY);
      rd(map[i], d & m, RESP_OKAY);
      // a partial write still launches and touches only enabled bytes
      wr(map[i], ~d, 4'b0101, RESP_OKAY);
      rd(map[i], ((d & 32'hff00ff00) | (~d & 32'h00ff00ff)) & m, RESP_OKAY);
    end
    for (int it = 0; it < 40; it++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        pw[k] = $random(seed);
        wr(OFF_PAT_W0 + 16'(4 * k), pw[k], 4'hf, RESP_OKAY);
      end
      d = $random(seed);
      col[0] = d[15:0];
      col[1] = d[31:16];
      wr(OFF_PAT_COL_LO, d, 4'hf, RESP_OKAY);
      d = $random(seed);
      col[2] = d[15:0];
      col[3] = d[31:16];
      wr(OFF_PAT_COL_HI, d, 4'hf, RESP_OKAY);
      rc = $random(seed) & 32'h1fff;
      rc[9:8] = it[1:0];
      if (rc[12]) rc[7:0] = 8'hc6;
      // corner: plain pattern copy code, rarely drawn at random
      else if (it[2:0] == 3'd5) rc[7:0] = 8'hf0;
      wr(OFF_RASTER, rc, 4'hf, RESP_OKAY);
      for (int j = 0; j < 8; j++)
      begin
        d = $random(seed);
        p.src = d[15:0];
        p.dst = j[0] ? d[15:0] : d[31:16];
        d = $random(seed);
        p.valid = d[0] | d[1];
        p.src_bit = d[2];
        p.pat_idx = d[9:3];
        @(posedge aclk);
        pix_in <= p;
        @(posedge aclk);
        #1;
        if (p.valid) chk_pix(pix_out, exp_pix(p));
      end
    end
    for (int v = 0; v < 32; v++)
    begin
      wr(OFF_LINE, {28'h0, v[3:0]}, 4'hf, RESP_OKAY);
      chk32({31'h0, line_fetch_a}, {31'h0, v[3]});
      @(posedge aclk);
      line_step <= 1'b1;
      line_minor <= v[4];
      @(posedge aclk);
      line_step <= 1'b0;
      #1;
      if (v[0]) s = '{v[4], !v[2], 1'b1, !v[1]};
      else s = '{1'b1, !v[1], v[4], !v[2]};
      chk_step(line_move, s);
      @(posedge aclk);
      #1;
      chk_step(line_move, '0);
    end
    for (int v = 0; v < 8; v++)
    begin
      wr(OFF_BLOCK, {23'h0, v[2], v[1:0], 6'h0}, 4'hf, RESP_OKAY);
      chk32({31'h0, source_expand}, {31'h0, v[0]});
      @(posedge aclk);
      row_end <= 1'b1;
      @(posedge aclk);
      row_end <= 1'b0;
      #1;
      s = (v[1:0] == 2'b11) ? 4'b1000 : {3'b001, v[2]};
      chk_step(row_move, s);
    end
    end_sim();
  end
endmodule
